// [rtl/uim_pkg.sv]
// Package: offsets, field positions, codes and reset values of the interrupt and modem block
package uim_pkg;
  // ==========================================================================
  // Register offsets on the 3-bit register port
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER = 3'h1;
  localparam logic [2:0] OFF_IIR = 3'h2;
  localparam logic [2:0] OFF_MCR = 3'h4;
  localparam logic [2:0] OFF_LSR = 3'h5;
  localparam logic [2:0] OFF_MSR = 3'h6;
  // ==========================================================================
  // Interrupt enable bits
  localparam int IE_RDA = 0;
  localparam int IE_THRE = 1;
  localparam int IE_RLS = 2;
  localparam int IE_MS = 3;
  // ==========================================================================
  // Line status bits
  localparam int LS_DR = 0;
  localparam int LS_OE = 1;
  localparam int LS_BI = 4;
  localparam int LS_THRE = 5;
  localparam int LS_TSRE = 6;
  // ==========================================================================
  // Modem control bits
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_AUX1 = 2;
  localparam int MC_AUX2 = 3;
  localparam int MC_LOOP = 4;
  // ==========================================================================
  // Modem status: change bits 0..3, states 4..7 (order cts, dsr, ri, dcd)
  localparam int MS_RI = 2;
  localparam int MS_STATE = 4;
  // ==========================================================================
  // Identification codes, bits 2..0
  localparam logic [2:0] ID_NONE = 3'h1;
  localparam logic [2:0] ID_RLS = 3'h6;
  localparam logic [2:0] ID_RDA = 3'h4;
  localparam logic [2:0] ID_THRE = 3'h2;
  localparam logic [2:0] ID_MS = 3'h0;
  // ==========================================================================
  // Reset values
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [4:0] MCR_RST = 5'h00;
  localparam logic [5:0] LSR_RST = 6'h20;
  localparam logic [3:0] MSD_RST = 4'h0;
endpackage : uim_pkg

// [rtl/uim_top.sv]
// Interrupt prioritisation, enables, modem control, loopback and modem status change logic
//
// Contract
// RQ1: Priority: line status, then data available, then holding empty, then modem.
// RQ2: Identification read freezes the reported source; only that one gets serviced.
// RQ3: Identification bit 0 is 0 when an enabled interrupt pends, else 1.
// RQ4: Codes 001 none, 110 line, 100 data, 010 holding empty, 000 modem.
// RQ5: Identification bits 3 to 7 read zero.
// RQ6: Overrun, parity, framing or break raise line interrupt; line status read clears.
// RQ7: Receiver buffer read clears the data available interrupt.
// RQ8: Holding empty cleared by identification read as source, or holding write.
// RQ9: Modem input changes raise modem interrupt; modem status read clears it.
// RQ10: Enable bits: 0 data, 1 holding empty, 2 line status, 3 modem.
// RQ11: Enable bits 4 to 7 read zero.
// RQ12: Interrupt output active high; all enables clear means no interrupt at all.
// RQ13: Status bits keep updating while interrupts are disabled.
// RQ14: Control bits 0..3 drive active-low pins inverted.
// RQ15: Loopback: tx pin marks, rx pin cut, shift looped, modem pins internal.
// RQ16: In loopback modem interrupts come from control bits, still enable gated.
// RQ17: Writing ones to low six line or low four modem status bits sets them.
// RQ18: Modem control bits 5 to 7 read zero.
// RQ19: Change bits set on input change; all cleared by modem status read.
// RQ20: Ring change bit sets only on ring on-to-off transition.
// RQ21: Any change bit at 1 makes a modem status interrupt.
// RQ22: Status bits 4..7 are input complements; loopback shows rts, dtr, aux1, aux2.
// RQ23: Modem inputs synchronised before change detection.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uim_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Receiver side
  input wire logic [7:0] rx_byte,
  input wire logic rx_data_set,
  input wire logic [3:0] rx_err_set,
  output logic rx_buf_read,
  output logic rx_shift_in,
  // Transmitter side
  input wire logic tx_shift_out,
  input wire logic thr_empty_set,
  input wire logic tsr_idle,
  output logic thr_load,
  output logic [7:0] thr_data,
  // Serial pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  // Modem pins, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic dtr_n,
  output logic rts_n,
  output logic aux1_n,
  output logic aux2_n,
  // Interrupt
  output logic interrupt_request_out
);

  // ==========================================================================
  // Register port decode
  // Offsets 3 and 7 decode to nothing: writes ignored, reads zero
  logic wr_data, wr_ier, wr_mcr, wr_lsr, wr_msr;
  logic rd_data, rd_iir, rd_lsr, rd_msr;
  assign wr_data = reg_wr && reg_addr == uim_pkg::OFF_DATA;
  assign wr_ier = reg_wr && reg_addr == uim_pkg::OFF_IER;
  assign wr_mcr = reg_wr && reg_addr == uim_pkg::OFF_MCR;
  assign wr_lsr = reg_wr && reg_addr == uim_pkg::OFF_LSR;
  assign wr_msr = reg_wr && reg_addr == uim_pkg::OFF_MSR;
  assign rd_data = reg_rd && reg_addr == uim_pkg::OFF_DATA;
  assign rd_iir = reg_rd && reg_addr == uim_pkg::OFF_IIR;
  assign rd_lsr = reg_rd && reg_addr == uim_pkg::OFF_LSR;
  assign rd_msr = reg_rd && reg_addr == uim_pkg::OFF_MSR;

  // ==========================================================================
  // Enable and modem control registers
  logic [3:0] ier_reg;
  logic [4:0] mcr_reg;
  logic loop_on;
  assign loop_on = mcr_reg[uim_pkg::MC_LOOP];

  // RQ10: enable bits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ier_reg <= uim_pkg::IER_RST;
    end else if (wr_ier) begin
      ier_reg <= reg_wdata[3:0];
    end
  end

  // RQ15: bit 4 selects loopback
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mcr_reg <= uim_pkg::MCR_RST;
    end else if (wr_mcr) begin
      mcr_reg <= reg_wdata[4:0];
    end
  end

  // ==========================================================================
  // Line status: dr, oe, pe, fe, bi, thre
  logic [5:0] lsr_reg;
  logic [5:0] lsr_next;

  always_comb begin
    lsr_next = lsr_reg;
    // RQ7: buffer read drops data ready
    if (rd_data) begin
      lsr_next[uim_pkg::LS_DR] = 1'b0;
    end
    // RQ6: line status read clears errors
    if (rd_lsr) begin
      lsr_next[uim_pkg::LS_BI:uim_pkg::LS_OE] = 4'h0;
    end
    // RQ8: holding write drops the empty bit
    if (wr_data) begin
      lsr_next[uim_pkg::LS_THRE] = 1'b0;
    end
    // RQ17: test writes set bits
    if (wr_lsr) begin
      lsr_next[uim_pkg::LS_DR] = reg_wdata[uim_pkg::LS_DR];
      lsr_next[5:1] = lsr_next[5:1] | reg_wdata[5:1];
    end
    // RQ13: hardware events set regardless of enables, and win over clears
    lsr_next[uim_pkg::LS_DR] = lsr_next[uim_pkg::LS_DR] | rx_data_set;
    lsr_next[uim_pkg::LS_BI:uim_pkg::LS_OE] = lsr_next[4:1] | rx_err_set;
    lsr_next[uim_pkg::LS_THRE] = lsr_next[uim_pkg::LS_THRE] | thr_empty_set;
  end

  // Bit 5 resets high: the holding register starts empty
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lsr_reg <= uim_pkg::LSR_RST;
    end else begin
      lsr_reg <= lsr_next;
    end
  end

  // ==========================================================================
  // Modem inputs: two-stage synchroniser, then true (asserted-high) state
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [3:0] mstate;
  logic [3:0] mstate_reg;
  logic [3:0] msd_reg;
  logic [3:0] msd_next;

  // Both stages reset to the idle pin level, so no false change follows reset
  // RQ23: synchronise before edge detection
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= 4'hf;
    end else begin
      pin_meta_reg <= {dcd_n, ri_n, dsr_n, cts_n};
    end
  end

  // Only the second stage reads the first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_sync_reg <= 4'hf;
    end else begin
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // RQ22: status follows inputs, or control bits in loopback
  // RQ16: loopback sources come from control bits
  always_comb begin
    if (loop_on) begin
      mstate = {mcr_reg[uim_pkg::MC_AUX2], mcr_reg[uim_pkg::MC_AUX1],
                mcr_reg[uim_pkg::MC_DTR], mcr_reg[uim_pkg::MC_RTS]};
    end else begin
      mstate = ~pin_sync_reg;
    end
  end

  // Previous state, the reference for change detection
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mstate_reg <= 4'h0;
    end else begin
      mstate_reg <= mstate;
    end
  end

  always_comb begin
    msd_next = msd_reg;
    // RQ19: status read clears all change bits
    if (rd_msr) begin
      msd_next = 4'h0;
    end
    // RQ17: test writes set change bits
    if (wr_msr) begin
      msd_next = msd_next | reg_wdata[3:0];
    end
    // RQ19: a change sets its bit, winning over a clear
    msd_next = msd_next | (mstate ^ mstate_reg);
    // Rebuilt on its own so that a rising ring edge cannot set it
    // RQ20: ring bit only on the on-to-off edge
    msd_next[uim_pkg::MS_RI] = (rd_msr ? 1'b0 : msd_reg[uim_pkg::MS_RI])
        | (wr_msr & reg_wdata[uim_pkg::MS_RI])
        | (mstate_reg[uim_pkg::MS_RI] & ~mstate[uim_pkg::MS_RI]);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      msd_reg <= uim_pkg::MSD_RST;
    end else begin
      msd_reg <= msd_next;
    end
  end

  // ==========================================================================
  // Holding-empty interrupt flag, separate from the status bit
  logic thri_reg;
  logic pend_rls, pend_rda, pend_thre, pend_ms;
  logic [2:0] id_code;

  // RQ12: every source gated by its enable
  // RQ6: line interrupt from error bits
  assign pend_rls = ier_reg[uim_pkg::IE_RLS] && lsr_reg[uim_pkg::LS_BI:uim_pkg::LS_OE] != 4'h0;
  assign pend_rda = ier_reg[uim_pkg::IE_RDA] && lsr_reg[uim_pkg::LS_DR];
  assign pend_thre = ier_reg[uim_pkg::IE_THRE] && thri_reg;
  // RQ9: modem status interrupt source
  // RQ21: any change bit gives a modem interrupt
  assign pend_ms = ier_reg[uim_pkg::IE_MS] && msd_reg != 4'h0;

  // The code of the strobe cycle is what a read returns and services
  // RQ1: fixed priority
  // RQ4: identification codes
  always_comb begin
    if (pend_rls) begin
      id_code = uim_pkg::ID_RLS;
    end else if (pend_rda) begin
      id_code = uim_pkg::ID_RDA;
    end else if (pend_thre) begin
      id_code = uim_pkg::ID_THRE;
    end else if (pend_ms) begin
      id_code = uim_pkg::ID_MS;
    end else begin
      id_code = uim_pkg::ID_NONE;
    end
  end

  // Enabling the source while the holding register is empty raises it at once
  // RQ8: cleared by holding write or by read that reports it
  // RQ2: only the source frozen in the read is serviced
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      thri_reg <= 1'b0;
    end else if (thr_empty_set || (wr_lsr && reg_wdata[uim_pkg::LS_THRE])
                 || (wr_ier && reg_wdata[uim_pkg::IE_THRE] && !ier_reg[uim_pkg::IE_THRE]
                     && lsr_reg[uim_pkg::LS_THRE])) begin
      thri_reg <= 1'b1;
    end else if (wr_data || (rd_iir && id_code == uim_pkg::ID_THRE)) begin
      thri_reg <= 1'b0;
    end
  end

  // One cycle behind the pending state, like the read data
  // RQ12: active-high output, registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interrupt_request_out <= 1'b0;
    end else begin
      interrupt_request_out <= pend_rls | pend_rda | pend_thre | pend_ms;
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe
  logic [7:0] rd_next;

  always_comb begin
    rd_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        uim_pkg::OFF_DATA: rd_next = rx_byte;
        // RQ11: upper enable bits zero
        uim_pkg::OFF_IER: rd_next = {4'h0, ier_reg};
        // RQ3: bit 0 low while pending
        // RQ5: upper identification bits zero
        uim_pkg::OFF_IIR: rd_next = {5'h00, id_code};
        // RQ18: upper control bits zero
        uim_pkg::OFF_MCR: rd_next = {3'h0, mcr_reg};
        uim_pkg::OFF_LSR: rd_next = {1'b0, tsr_idle, lsr_reg};
        uim_pkg::OFF_MSR: rd_next = {mstate_reg, msd_reg};
        default: rd_next = 8'h00;
      endcase
    end
  end

  // Held at zero outside the answer cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_next;
    end
  end

  // ==========================================================================
  // Datapath strobes toward receiver and transmitter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_buf_read <= 1'b0;
    end else begin
      rx_buf_read <= rd_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      thr_load <= 1'b0;
    end else begin
      thr_load <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      thr_data <= 8'h00;
    end else if (wr_data) begin
      thr_data <= reg_wdata;
    end
  end

  // ==========================================================================
  // Pins and loopback path
  // RQ15: tx pin held at mark in loopback
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serial_tx_pin <= 1'b1;
    end else begin
      serial_tx_pin <= loop_on ? 1'b1 : tx_shift_out;
    end
  end

  // RQ15: rx pin cut, shift output looped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_shift_in <= 1'b1;
    end else begin
      rx_shift_in <= loop_on ? tx_shift_out : serial_rx_pin;
    end
  end

  // Modem outputs rest inactive in loopback; the control bits go inward instead
  // RQ14: control bits drive pins inverted
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      aux1_n <= 1'b1;
      aux2_n <= 1'b1;
    end else begin
      dtr_n <= loop_on | ~mcr_reg[uim_pkg::MC_DTR];
      rts_n <= loop_on | ~mcr_reg[uim_pkg::MC_RTS];
      aux1_n <= loop_on | ~mcr_reg[uim_pkg::MC_AUX1];
      aux2_n <= loop_on | ~mcr_reg[uim_pkg::MC_AUX2];
    end
  end

endmodule : uim_top
`default_nettype wire

// [test/uim_props.sv]
// Port checker for the interrupt and modem block
`timescale 1ns/1ps
`default_nettype none
module uim_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Serial and modem pins
  input wire logic rx_shift_in,
  input wire logic tx_shift_out,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic aux1_n,
  input wire logic aux2_n,
  input wire logic interrupt_request_out
);
  // ==========
  // Shadow of the enable and control registers
  logic [3:0] ier_reg;
  logic [4:0] mcr_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ier_reg <= 4'h0;
    else if (reg_wr && reg_addr == 3'h1) ier_reg <= reg_wdata[3:0];
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) mcr_reg <= 5'h00;
    else if (reg_wr && reg_addr == 3'h4) mcr_reg <= reg_wdata[4:0];
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ==========
  // Properties
  property p_iir_zero;
    reg_rd && reg_addr == 3'h2 |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_iir_zero: assert property (p_iir_zero) else $error("id high bits set");
  property p_iir_pend;
    reg_rd && reg_addr == 3'h2 |=> reg_rdata[0] == !interrupt_request_out;
  endproperty
  a_iir_pend: assert property (p_iir_pend) else $error("id bit0 vs irq");
  property p_ier_zero;
    reg_rd && reg_addr == 3'h1 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_ier_zero: assert property (p_ier_zero) else $error("enable high bits set");
  property p_mcr_zero;
    reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_mcr_zero: assert property (p_mcr_zero) else $error("control high bits set");
  property p_irq_off;
    $past(rstn) && $past(ier_reg) == 4'h0 |-> !interrupt_request_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_pins;
    $past(rstn) |-> {aux2_n, aux1_n, rts_n, dtr_n} ==
      ($past(mcr_reg[4]) ? 4'hf : ~$past(mcr_reg[3:0]));
  endproperty
  a_pins: assert property (p_pins) else $error("modem outputs wrong");
  property p_tx_mark;
    $past(rstn) |-> serial_tx_pin == ($past(mcr_reg[4]) || $past(tx_shift_out));
  endproperty
  a_tx_mark: assert property (p_tx_mark) else $error("serial out wrong");
  property p_rx_loop;
    $past(rstn) |-> rx_shift_in ==
      ($past(mcr_reg[4]) ? $past(tx_shift_out) : $past(serial_rx_pin));
  endproperty
  a_rx_loop: assert property (p_rx_loop) else $error("receive input wrong");
endmodule : uim_props
bind uim_top uim_props u_props (
  .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_shift_in(rx_shift_in),
  .tx_shift_out(tx_shift_out), .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
  .dtr_n(dtr_n), .rts_n(rts_n), .aux1_n(aux1_n), .aux2_n(aux2_n),
  .interrupt_request_out(interrupt_request_out)
);
`default_nettype wire

// [test/uim_modem.sv]
// Modem partner: drives the active-low handshake lines from a requested state
`timescale 1ns/1ps
`default_nettype none
module uim_modem #(
  parameter int DELAY = 3
) (
  // Requested asserted lines, order dcd ri dsr cts
  input wire logic [3:0] line_on,
  // Lines towards the device
  output wire logic cts_n,
  output wire logic dsr_n,
  output wire logic ri_n,
  output wire logic dcd_n
);
  // Lines move DELAY after the device clock edge that sets line_on, not on the edge itself
  assign #DELAY {dcd_n, ri_n, dsr_n, cts_n} = ~line_on;
endmodule : uim_modem
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the interrupt and modem block against a register model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rstn, reg_wr, reg_rd, rx_data_set, tx_shift_out, thr_empty_set, tsr_idle;
  logic serial_rx_pin, rx_buf_read, rx_shift_in, thr_load, serial_tx_pin, interrupt_request_out;
  logic cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, aux1_n, aux2_n, m_tf;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_byte, thr_data;
  logic [3:0] rx_err_set, line_on, m_ier, m_msd, m_st;
  logic [4:0] m_mcr;
  logic [5:0] m_lsr;
  int num_errors, compares, seed, cycles;
  uim_top dut (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte(rx_byte), .rx_data_set(rx_data_set),
    .rx_err_set(rx_err_set), .rx_buf_read(rx_buf_read), .rx_shift_in(rx_shift_in),
    .tx_shift_out(tx_shift_out), .thr_empty_set(thr_empty_set), .tsr_idle(tsr_idle),
    .thr_load(thr_load), .thr_data(thr_data), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n),
    .dtr_n(dtr_n), .rts_n(rts_n), .aux1_n(aux1_n), .aux2_n(aux2_n),
    .interrupt_request_out(interrupt_request_out)
  );
  uim_modem u_modem (
    .line_on(line_on), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Serial lines toggle at random; hang guard
  always @(posedge clock) begin
    tx_shift_out <= 1'($random(seed));
    serial_rx_pin <= 1'($random(seed));
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      conclude();
    end
  end
  // ==========
  // Model
  function automatic logic [2:0] m_iir();
    if (m_ier[2] && |m_lsr[4:1]) return 3'h6;
    if (m_ier[0] && m_lsr[0]) return 3'h4;
    if (m_ier[1] && m_tf) return 3'h2;
    if (m_ier[3] && |m_msd) return 3'h0;
    return 3'h1;
  endfunction : m_iir
  function automatic logic [3:0] m_state();
    return m_mcr[4] ? {m_mcr[3], m_mcr[2], m_mcr[0], m_mcr[1]} : line_on;
  endfunction : m_state
  task automatic m_upd(input logic [3:0] ns);
    logic [3:0] d;
    d = m_st ^ ns;
    m_msd |= {d[3], m_st[2] & ~ns[2], d[1], d[0]};
    m_st = ns;
  endtask : m_upd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic irq_chk();
    repeat (3) @(posedge clock);
    #1 chk({7'h00, interrupt_request_out}, {7'h00, m_iir() != 3'h1});
  endtask : irq_chk
  // ==========
  // Register port and stimulus
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a == 3'h0) {m_lsr[5], m_tf} = 2'b00;
    if (a == 3'h1) m_tf = m_tf | (!m_ier[1] & d[1] & m_lsr[5]);
    if (a == 3'h1) m_ier = d[3:0];
    if (a == 3'h4) m_mcr = d[4:0];
    if (a == 3'h5) m_lsr = {m_lsr[5:1] | d[5:1], d[0]};
    if (a == 3'h6) m_msd |= d[3:0];
    if (a == 3'h5) m_tf = m_tf | d[5];
    m_upd(m_state());
    #1 chk({7'h00, thr_load}, {7'h00, a == 3'h0});
    if (a == 3'h0) chk(thr_data, d);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    logic [7:0] e;
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rx_byte <= 8'($random(seed));
    @(posedge clock);
    reg_rd <= 1'b0;
    e = 8'h00;
    if (a == 3'h0) e = rx_byte;
    if (a == 3'h1) e = {4'h0, m_ier};
    if (a == 3'h2) e = {5'h00, m_iir()};
    if (a == 3'h4) e = {3'h0, m_mcr};
    if (a == 3'h5) e = {1'b0, tsr_idle, m_lsr};
    if (a == 3'h6) e = {m_st, m_msd};
    #1 chk(reg_rdata, e);
    chk({7'h00, rx_buf_read}, {7'h00, a == 3'h0});
    if (a == 3'h0) m_lsr[0] = 1'b0;
    if (a == 3'h2 && e[2:0] == 3'h2) m_tf = 1'b0;
    if (a == 3'h5) m_lsr[4:1] = 4'h0;
    if (a == 3'h6) m_msd = 4'h0;
  endtask : rd
  task automatic pulse(input logic dset, input logic [3:0] err, input logic tset);
    @(posedge clock);
    rx_data_set <= dset;
    rx_err_set <= err;
    thr_empty_set <= tset;
    @(posedge clock);
    {rx_data_set, rx_err_set, thr_empty_set} <= 6'h00;
    m_lsr = m_lsr | {tset, err, dset};
    m_tf = m_tf | tset;
  endtask : pulse
  task automatic line(input logic [3:0] v);
    @(posedge clock);
    line_on <= v;
    repeat (6) @(posedge clock);
    m_upd(m_state());
  endtask : line
  task automatic conclude();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // ==========
  // Main sequence
  initial begin
    seed = 23843;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    {rstn, reg_wr, reg_rd, rx_data_set, thr_empty_set} = 5'h00;
    {reg_addr, reg_wdata, rx_byte, rx_err_set, line_on} = '0;
    tsr_idle = 1'($random(seed));
    {m_ier, m_msd, m_st, m_mcr, m_tf} = '0;
    m_lsr = 6'h20;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    repeat (6) begin
      wr(3'h1, 8'($random(seed)));
      rd(3'h1);
      wr(3'h4, 8'($random(seed)));
      rd(3'h4);
      rd(3'h6);
      rd(3'h2);
      irq_chk();
    end
    wr(3'h4, 8'h00);
    rd(3'h4);
    wr(3'h1, 8'h0f);
    for (int k = 0; k < 4; k++) begin
      wr(3'h6, 8'(1 << k));
      rd(3'h2);
      pulse(1'b1, 4'h1 << k, 1'b1);
      irq_chk();
      rd(3'h2);
      rd(3'h5);
      rd(3'h2);
      rd(3'h0);
      rd(3'h2);
      rd(3'h2);
      rd(3'h6);
      rd(3'h2);
    end
    wr(3'h5, 8'h3f);
    rd(3'h2);
    rd(3'h5);
    rd(3'h0);
    irq_chk();
    wr(3'h0, 8'($random(seed)));
    rd(3'h2);
    rd(3'h5);
    irq_chk();
    for (int k = 0; k < 16; k++) begin
      wr(3'h1, {4'h0, k[3], 3'h0});
      line(k[0] ? 4'h0 : 4'h1 << k[2:1]);
      irq_chk();
      rd(3'h2);
      rd(3'h6);
    end
    wr(3'h1, 8'h08);
    for (int v = 0; v < 16; v++) begin
      wr(3'h4, {4'h1, v[3:0]});
      rd(3'h4);
      irq_chk();
      rd(3'h6);
    end
    conclude();
  end
endmodule : tb
`default_nettype wire
